// ### core/cews_cfg.svh
`ifndef CEWS_CFG_SVH
`define CEWS_CFG_SVH
// ****************************************
// Line states
// ****************************************
`define CEWS_ST_I   2'h0
`define CEWS_ST_SC  2'h1
`define CEWS_ST_UC  2'h2
`define CEWS_ST_UD  2'h3
// ****************************************
// Write-class request codes
// ****************************************
`define CEWS_WR_NOSNOOP   3'h0
`define CEWS_WR_UNIQUE    3'h1
`define CEWS_WR_LINEUNIQ  3'h2
`define CEWS_WR_BACK      3'h3
`define CEWS_WR_CLEAN     3'h4
`define CEWS_WR_EVICTW    3'h5
`define CEWS_WR_EVICT     3'h6
// ****************************************
// Coherent read/upgrade codes
// ****************************************
`define CEWS_RD_UNIQUE    2'h0
`define CEWS_RD_MAKEUNIQ  2'h1
`define CEWS_RD_CLNUNIQ   2'h2
// ****************************************
// Snoop codes; all but OTHER invalidate
// ****************************************
`define CEWS_SN_RDUNIQ    2'h0
`define CEWS_SN_CLNINV    2'h1
`define CEWS_SN_MKINV     2'h2
`define CEWS_SN_OTHER     2'h3
`define CEWS_CNT_ONE      8'h01
`endif

// ### core/cews_pkg.sv
package cews_pkg;
  typedef enum logic [2:0] {
    CEWS_SEQ_IDLE,
    CEWS_SEQ_WAIT,
    CEWS_SEQ_LOST,
    CEWS_SEQ_STORE,
    CEWS_SEQ_REFETCH,
    CEWS_SEQ_PWB
  } cews_seq_e;
endpackage : cews_pkg

// ### core/cews_sequencer.sv
`timescale 1ns/1ps
`default_nettype none
`include "cews_cfg.svh"
module cews_sequencer #(
  parameter int CNT_W = 8
) (
  input  wire logic       clk,
  input  wire logic       arst_n,
  input  wire logic       cfg_we_enable,
  input  wire logic       cfg_we_declared,
  input  wire logic       cfg_snoop_filter,
  input  wire logic       cfg_cd_data,
  input  wire logic       cfg_pwb_alt,
  input  wire logic       wr_req,
  input  wire logic [2:0] wr_kind,
  input  wire logic [1:0] wr_line_st,
  input  wire logic       wr_spec,
  input  wire logic       wr_shareable,
  input  wire logic       wr_has_data,
  input  wire logic       wr_done,
  input  wire logic [2:0] wr_done_kind,
  input  wire logic       rd_req,
  input  wire logic [1:0] rd_kind,
  input  wire logic       rd_full_line,
  input  wire logic       rd_done,
  input  wire logic       sn_valid,
  input  wire logic [1:0] sn_kind,
  input  wire logic       sn_hit,
  output logic            wr_issue_ff,
  output logic            wr_stall_ff,
  output logic            line_inval_ff,
  output logic            sn_resp_ff,
  output logic            store_go_ff,
  output logic            refetch_ff,
  output logic            pwb_ff,
  output logic            uniq_busy_ff,
  output logic            evc_busy_ff
);
  // ****************************************
  // Decoding helpers
  // ****************************************
  function automatic logic is_evc(input logic [2:0] k);
    return k == `CEWS_WR_BACK || k == `CEWS_WR_CLEAN || k == `CEWS_WR_EVICTW || k == `CEWS_WR_EVICT;
  endfunction : is_evc
  function automatic logic is_uniq(input logic [2:0] k);
    return k == `CEWS_WR_UNIQUE || k == `CEWS_WR_LINEUNIQ;
  endfunction : is_uniq
  function automatic logic is_inv_snoop(input logic [1:0] k);
    return k != `CEWS_SN_OTHER;
  endfunction : is_inv_snoop

  logic [CNT_W-1:0]   uniq_cnt_ff;
  logic [CNT_W-1:0]   evc_cnt_ff;
  cews_pkg::cews_seq_e seq_ff;
  logic [1:0]         seq_kind_ff;
  logic               seq_full_ff;
  logic               we_ok;
  logic               legal;
  logic               issue;
  logic               uniq_issue;
  logic               evc_issue;
  logic               uniq_done;
  logic               evc_done;
  logic               seq_lost;

  assign we_ok = cfg_we_enable && cfg_we_declared;

  // Copy counts as lost when the killing snoop meets the completion
  assign seq_lost = seq_ff == cews_pkg::CEWS_SEQ_LOST || (sn_valid && sn_hit && is_inv_snoop(sn_kind));

  // ****************************************
  // Issue legality and ordering
  // ****************************************
  always_comb begin
    unique case (wr_kind)
      `CEWS_WR_EVICTW: legal = we_ok && wr_line_st == `CEWS_ST_UC && !wr_spec;
      `CEWS_WR_EVICT: legal = cfg_snoop_filter && wr_shareable && !wr_has_data &&
                        (wr_line_st == `CEWS_ST_UC || wr_line_st == `CEWS_ST_SC);
      `CEWS_WR_UNIQUE, `CEWS_WR_LINEUNIQ: legal = cfg_cd_data && evc_cnt_ff == '0;
      default: legal = 1'b1;
    endcase
    if (is_evc(wr_kind) && uniq_cnt_ff != '0)
      legal = 1'b0;
  end

  assign issue      = wr_req && legal;
  assign uniq_issue = issue && is_uniq(wr_kind);
  assign evc_issue  = issue && is_evc(wr_kind);
  assign uniq_done  = wr_done && is_uniq(wr_done_kind);
  assign evc_done   = wr_done && is_evc(wr_done_kind);

  // ****************************************
  // Outstanding counters
  // ****************************************
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      uniq_cnt_ff <= '0;
      evc_cnt_ff  <= '0;
    end else begin
      uniq_cnt_ff <= uniq_cnt_ff + CNT_W'(uniq_issue) - CNT_W'(uniq_done);
      evc_cnt_ff  <= evc_cnt_ff + CNT_W'(evc_issue) - CNT_W'(evc_done);
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wr_issue_ff   <= 1'b0;
      wr_stall_ff   <= 1'b0;
      uniq_busy_ff  <= 1'b0;
      evc_busy_ff   <= 1'b0;
    end else begin
      wr_issue_ff  <= issue;
      wr_stall_ff  <= wr_req && !legal;
      uniq_busy_ff <= (uniq_cnt_ff + CNT_W'(uniq_issue) - CNT_W'(uniq_done)) != '0;
      evc_busy_ff  <= (evc_cnt_ff + CNT_W'(evc_issue) - CNT_W'(evc_done)) != '0;
    end
  end

  // ****************************************
  // Snoop answer, never waits on writes
  // ****************************************
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sn_resp_ff <= 1'b0;
    end else begin
      sn_resp_ff <= sn_valid;
    end
  end

  // ****************************************
  // Overlapping store sequencer
  // ****************************************
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      seq_ff        <= cews_pkg::CEWS_SEQ_IDLE;
      seq_kind_ff   <= `CEWS_RD_UNIQUE;
      seq_full_ff   <= 1'b0;
      line_inval_ff <= 1'b0;
      store_go_ff   <= 1'b0;
      refetch_ff    <= 1'b0;
      pwb_ff        <= 1'b0;
    end else begin
      store_go_ff   <= 1'b0;
      refetch_ff    <= 1'b0;
      pwb_ff        <= 1'b0;
      line_inval_ff <= issue && wr_kind inside {`CEWS_WR_EVICTW, `CEWS_WR_EVICT};
      unique case (seq_ff)
        cews_pkg::CEWS_SEQ_IDLE: begin
          if (rd_req) begin
            seq_ff      <= cews_pkg::CEWS_SEQ_WAIT;
            seq_kind_ff <= rd_kind;
            seq_full_ff <= rd_full_line;
          end
        end
        cews_pkg::CEWS_SEQ_WAIT, cews_pkg::CEWS_SEQ_LOST: begin
          if (sn_valid && sn_hit && is_inv_snoop(sn_kind)) begin
            line_inval_ff <= 1'b1;
            seq_ff        <= rd_done ? cews_pkg::CEWS_SEQ_IDLE : cews_pkg::CEWS_SEQ_LOST;
          end
          if (rd_done) begin
            if (!seq_lost || seq_kind_ff != `CEWS_RD_CLNUNIQ || seq_full_ff) begin
              store_go_ff <= 1'b1;
              seq_ff      <= cews_pkg::CEWS_SEQ_IDLE;
            end else if (cfg_pwb_alt) begin
              pwb_ff        <= 1'b1;
              line_inval_ff <= 1'b1;
              seq_ff        <= cews_pkg::CEWS_SEQ_IDLE;
            end else begin
              refetch_ff  <= 1'b1;
              seq_kind_ff <= `CEWS_RD_UNIQUE;
              seq_ff      <= cews_pkg::CEWS_SEQ_WAIT;
            end
          end
        end
        default: seq_ff <= cews_pkg::CEWS_SEQ_IDLE;
      endcase
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  evict_gate_a: assert property (@(posedge clk) disable iff (!arst_n)
    issue && is_evc(wr_kind) |-> uniq_cnt_ff == '0)
    else $error("eviction issued during unique write");
  uniq_gate_a: assert property (@(posedge clk) disable iff (!arst_n)
    issue && is_uniq(wr_kind) |-> evc_cnt_ff == '0)
    else $error("unique write issued with evictions pending");
  we_state_a: assert property (@(posedge clk) disable iff (!arst_n)
    issue && wr_kind == `CEWS_WR_EVICTW |-> wr_line_st == `CEWS_ST_UC && we_ok && !wr_spec)
    else $error("illegal write evict");
  we_inval_a: assert property (@(posedge clk) disable iff (!arst_n)
    issue && wr_kind == `CEWS_WR_EVICTW |=> line_inval_ff)
    else $error("write evict did not invalidate");
  ev_filter_a: assert property (@(posedge clk) disable iff (!arst_n)
    issue && wr_kind == `CEWS_WR_EVICT |-> cfg_snoop_filter && wr_shareable && !wr_has_data)
    else $error("illegal evict");
  snoop_resp_a: assert property (@(posedge clk) disable iff (!arst_n)
    sn_valid |=> sn_resp_ff)
    else $error("snoop not answered");
  lost_store_a: assert property (@(posedge clk) disable iff (!arst_n)
    seq_ff == cews_pkg::CEWS_SEQ_LOST && rd_done && seq_kind_ff == `CEWS_RD_CLNUNIQ && !seq_full_ff
    |=> !store_go_ff && (refetch_ff || pwb_ff))
    else $error("store after lost copy");
  snp_inval_a: assert property (@(posedge clk) disable iff (!arst_n)
    seq_ff == cews_pkg::CEWS_SEQ_WAIT && sn_valid && sn_hit && is_inv_snoop(sn_kind) |=> line_inval_ff)
    else $error("snoop did not invalidate");

  // ****************************************
  // Issue legality, sequencer and counter checks
  // ****************************************
  sequence inv_snoop_s;
    sn_valid && sn_hit && is_inv_snoop(sn_kind);
  endsequence
  sequence cu_lost_done_s;
    rd_done && seq_kind_ff == `CEWS_RD_CLNUNIQ && !seq_full_ff && seq_lost;
  endsequence
  issue_excl_a: assert property (@(posedge clk) disable iff (!arst_n)
    wr_issue_ff |-> !wr_stall_ff)
    else $error("issue and stall together");
  uniq_busy_a: assert property (@(posedge clk) disable iff (!arst_n)
    uniq_busy_ff == (uniq_cnt_ff != '0))
    else $error("unique busy flag wrong");
  evc_busy_a: assert property (@(posedge clk) disable iff (!arst_n)
    evc_busy_ff == (evc_cnt_ff != '0))
    else $error("eviction busy flag wrong");
  uniq_uflow_a: assert property (@(posedge clk) disable iff (!arst_n)
    uniq_done |-> uniq_cnt_ff != '0)
    else $error("unique counter underflow");
  evc_uflow_a: assert property (@(posedge clk) disable iff (!arst_n)
    evc_done |-> evc_cnt_ff != '0)
    else $error("eviction counter underflow");
  uniq_cd_a: assert property (@(posedge clk) disable iff (!arst_n)
    issue && is_uniq(wr_kind) |-> cfg_cd_data)
    else $error("unique write without snoop data path");
  we_disable_a: assert property (@(posedge clk) disable iff (!arst_n)
    !cfg_we_enable |-> !(issue && wr_kind == `CEWS_WR_EVICTW))
    else $error("write evict while disabled");
  we_undecl_a: assert property (@(posedge clk) disable iff (!arst_n)
    !cfg_we_declared |-> !(issue && wr_kind == `CEWS_WR_EVICTW))
    else $error("write evict while undeclared");
  we_spec_a: assert property (@(posedge clk) disable iff (!arst_n)
    issue && wr_kind == `CEWS_WR_EVICTW |-> !wr_spec)
    else $error("write evict of speculative line");
  ev_nodata_a: assert property (@(posedge clk) disable iff (!arst_n)
    issue && wr_kind == `CEWS_WR_EVICT |-> !wr_has_data && wr_shareable)
    else $error("evict with data or non-shareable");
  ev_inval_a: assert property (@(posedge clk) disable iff (!arst_n)
    issue && wr_kind == `CEWS_WR_EVICT |=> line_inval_ff)
    else $error("evict did not invalidate");
  nosnoop_go_a: assert property (@(posedge clk) disable iff (!arst_n)
    wr_req && wr_kind == `CEWS_WR_NOSNOOP && uniq_cnt_ff == '0 |-> legal)
    else $error("plain write refused");
  snp_order_a: assert property (@(posedge clk) disable iff (!arst_n)
    inv_snoop_s ##0 seq_ff != cews_pkg::CEWS_SEQ_IDLE |=> sn_resp_ff && line_inval_ff)
    else $error("snoop answer or invalidate missing");
  cu_lost_a: assert property (@(posedge clk) disable iff (!arst_n)
    cu_lost_done_s ##0 seq_ff != cews_pkg::CEWS_SEQ_IDLE |=> !store_go_ff)
    else $error("store after lost partial line");
  refetch_kind_a: assert property (@(posedge clk) disable iff (!arst_n)
    refetch_ff |-> seq_ff == cews_pkg::CEWS_SEQ_WAIT && seq_kind_ff == `CEWS_RD_UNIQUE)
    else $error("refetch not as read unique");
  refetch_alt_a: assert property (@(posedge clk) disable iff (!arst_n)
    refetch_ff |-> !pwb_ff)
    else $error("refetch and partial write back together");
  pwb_inval_a: assert property (@(posedge clk) disable iff (!arst_n)
    pwb_ff |-> line_inval_ff && !store_go_ff)
    else $error("partial write back kept line");
  full_cu_a: assert property (@(posedge clk) disable iff (!arst_n)
    rd_done && seq_ff != cews_pkg::CEWS_SEQ_IDLE && seq_kind_ff == `CEWS_RD_CLNUNIQ && seq_full_ff
    |=> store_go_ff)
    else $error("full line store withheld");
  store_done_a: assert property (@(posedge clk) disable iff (!arst_n)
    store_go_ff |-> $past(rd_done))
    else $error("store before completion");
  store_pulse_a: assert property (@(posedge clk) disable iff (!arst_n)
    store_go_ff |=> !store_go_ff)
    else $error("store pulse too long");
endmodule : cews_sequencer
`default_nettype wire

// ### dv/cews_icn_model.sv
`timescale 1ns/1ps
`default_nettype none
module cews_icn_model #(
  parameter int LAT = 8
) (
  input  wire logic       clk,
  input  wire logic       arst_n,
  input  wire logic       issue,
  input  wire logic [2:0] kind,
  output logic            done,
  output logic [2:0]      done_kind
);
  int cnt;
  // ****************************************
  // One write in flight, completes after LAT
  // ****************************************
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt <= 0;
      done <= 1'b0;
      done_kind <= 3'h7;
    end else if (issue) begin
      cnt <= LAT;
      done_kind <= kind;
      done <= 1'b0;
    end else begin
      done <= (cnt == 1);
      cnt <= (cnt > 0) ? cnt - 1 : 0;
    end
  end
endmodule : cews_icn_model
`default_nettype wire

// ### dv/coherent_evict_write_sequencer_tb.sv
`timescale 1ns/1ps
`default_nettype none
module coherent_evict_write_sequencer_tb;
  logic clk, arst_n, en, decl, sf, cd, pwb_alt, wr_req, spec, shr, dat, wr_done, rd_req, full, rd_done, sn_valid, hit;
  logic [2:0] kind, done_kind;
  logic [1:0] st, rd_kind, sn_kind;
  logic issue, stall, inval, sn_resp, store_go, refetch, pwb, ubusy, ebusy;
  int err_count, samples_checked, cyc, i;
  localparam logic [12:0] ROWS [14] = '{13'h165f, 13'h155e, 13'h16de, 13'h164e, 13'h1656, 13'h195f, 13'h1a5a,
    13'h1a7e, 13'h1a1e, 13'h045c, 13'h085f, 13'h0f5f, 13'h135f, 13'h005f};
  cews_sequencer #(.CNT_W(8)) dut_u (.clk(clk), .arst_n(arst_n), .cfg_we_enable(en), .cfg_we_declared(decl),
    .cfg_snoop_filter(sf), .cfg_cd_data(cd), .cfg_pwb_alt(pwb_alt), .wr_req(wr_req), .wr_kind(kind),
    .wr_line_st(st), .wr_spec(spec), .wr_shareable(shr), .wr_has_data(dat), .wr_done(wr_done),
    .wr_done_kind(done_kind), .rd_req(rd_req), .rd_kind(rd_kind), .rd_full_line(full), .rd_done(rd_done),
    .sn_valid(sn_valid), .sn_kind(sn_kind), .sn_hit(hit), .wr_issue_ff(issue), .wr_stall_ff(stall),
    .line_inval_ff(inval), .sn_resp_ff(sn_resp), .store_go_ff(store_go), .refetch_ff(refetch), .pwb_ff(pwb),
    .uniq_busy_ff(ubusy), .evc_busy_ff(ebusy));
  cews_icn_model #(.LAT(8)) icn_u (.clk(clk), .arst_n(arst_n), .issue(issue), .kind(kind), .done(wr_done),
    .done_kind(done_kind));
  // ****************************************
  // Tasks
  // ****************************************
  task automatic chk(input logic got, input logic exp);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH %0t got %b exp %b", $time, got, exp);
    end
  endtask : chk
  task automatic finish_test();
    if (err_count == 0 && samples_checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : finish_test
  task automatic wreq(input logic [12:0] r);
    @(posedge clk);
    {kind, st, spec, shr, dat, en, decl, sf, cd} <= r[12:1];
    wr_req <= 1'b1;
    @(posedge clk);
    wr_req <= 1'b0;
    #1;
    chk(issue, r[0]);
    chk(stall, ~r[0]);
    if (r[12:11] == 2'h3 || r[12:10] == 3'h5) chk(inval, r[0]);
  endtask : wreq
  task automatic drain();
    repeat (12) @(posedge clk);
    #1;
    chk(ubusy | ebusy, 1'b0);
  endtask : drain
  task automatic rd(input logic [1:0] k, input logic f);
    @(posedge clk);
    {rd_req, rd_kind, full} <= {1'b1, k, f};
    @(posedge clk);
    rd_req <= 1'b0;
  endtask : rd
  task automatic sn(input logic [1:0] k, input logic h);
    @(posedge clk);
    {sn_valid, sn_kind, hit} <= {1'b1, k, h};
    @(posedge clk);
    sn_valid <= 1'b0;
    #1;
    chk(sn_resp, 1'b1);
    chk(inval, k != 2'h3 && h);
  endtask : sn
  task automatic rdone();
    @(posedge clk);
    rd_done <= 1'b1;
    @(posedge clk);
    rd_done <= 1'b0;
    #1;
  endtask : rdone
  // ****************************************
  // Clock, timeout, sequence
  // ****************************************
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      err_count++;
      finish_test();
    end
  end
  initial begin
    {arst_n, en, decl, sf, cd, pwb_alt, wr_req, spec, shr, dat, rd_req, full, rd_done, sn_valid} = '0;
    {kind, st, rd_kind, sn_kind} = '0;
    hit = 1'b1;
    repeat (12) @(posedge clk);
    chk(issue | stall | inval | sn_resp | store_go | refetch | pwb | ubusy | ebusy, 1'b0);
    arst_n <= 1'b1;
    for (i = 0; i < 14; i++) begin
      wreq(ROWS[i]);
      drain();
    end
    wreq(13'h0f5f);
    wreq(13'h045e);
    drain();
    wreq(13'h045f);
    chk(ubusy, 1'b1);
    wreq(13'h165e);
    sn(2'h3, 1'b1);
    drain();
    for (i = 0; i < 3; i++) begin
      rd(2'(i % 2), 1'b1);
      sn(2'(i), 1'b1);
      rdone();
      chk(store_go, 1'b1);
    end
    rd(2'h0, 1'b1);
    sn(2'h0, 1'b0);
    rdone();
    chk(store_go, 1'b1);
    rd(2'h2, 1'b0);
    sn(2'h1, 1'b1);
    rdone();
    chk(refetch, 1'b1);
    chk(store_go, 1'b0);
    rdone();
    chk(store_go, 1'b1);
    rd(2'h2, 1'b0);
    @(posedge clk);
    {sn_valid, sn_kind, rd_done} <= {1'b1, 2'h1, 1'b1};
    @(posedge clk);
    {sn_valid, rd_done} <= 2'b00;
    #1;
    chk(refetch, 1'b1);
    chk(inval, 1'b1);
    rdone();
    chk(store_go, 1'b1);
    @(posedge clk);
    pwb_alt <= 1'b1;
    rd(2'h2, 1'b0);
    sn(2'h2, 1'b1);
    rdone();
    chk(pwb, 1'b1);
    chk(inval, 1'b1);
    @(posedge clk);
    pwb_alt <= 1'b0;
    rd(2'h2, 1'b1);
    sn(2'h0, 1'b1);
    rdone();
    chk(store_go, 1'b1);
    finish_test();
  end
endmodule : coherent_evict_write_sequencer_tb
`default_nettype wire
